// >>> hdl/dtod_map.vh
/*
 * Constants for the data-transfer decode and execute block: operand size
 * codes, operation kinds, operand sources, address forms, field lengths, stack byte counts and the stack register index.
 * Assumes it is included by bare name from hdl/ and defines nothing else.
 */
`ifndef DTOD_MAP_VH
`define DTOD_MAP_VH

// Operand size codes
`define DTOD_SZ_BYTE      2'h0
`define DTOD_SZ_WORD      2'h1
`define DTOD_SZ_LONG      2'h2

// Byte counts per size, used for stack adjust
`define DTOD_BYTES_WORD   32'h0000_0002
`define DTOD_BYTES_LONG   32'h0000_0004

// Operation kinds
`define DTOD_OP_XFER      3'h0
`define DTOD_OP_PULL      3'h1
`define DTOD_OP_PLACE     3'h2
`define DTOD_OP_PERIPH_RD 3'h3
`define DTOD_OP_PERIPH_WR 3'h4

// Source of a general transfer
`define DTOD_SRC_REG      2'h0
`define DTOD_SRC_IMM      2'h1
`define DTOD_SRC_MEM      2'h2

// Effective address forms
`define DTOD_EA_ABS       2'h0
`define DTOD_EA_IND       2'h1
`define DTOD_EA_DISP      2'h2

// Operand field lengths
`define DTOD_LEN_3        2'h0
`define DTOD_LEN_8        2'h1
`define DTOD_LEN_16       2'h2
`define DTOD_LEN_24       2'h3

// Index of the stack register among the long registers
`define DTOD_STACK_IDX    3'h7

`endif

// >>> hdl/dtod_regfile.v
/*
 * General register file: eight 32-bit long registers, also seen as sixteen
 * 16-bit halves and sixteen 8-bit bytes over the same storage.
 * Assumes one write per cycle from the executor; reads are combinational.
 */
`timescale 1ns/10ps
`default_nettype none

`include "dtod_map.vh"

module dtod_regfile (
	// Clock
	input  wire        sys_clk_i,
	// Sized read port A (source operand)
	input  wire [3:0]  ra_idx_i,
	input  wire [1:0]  ra_size_i,
	output wire [31:0] ra_data_o,
	// Sized read port B (observation)
	input  wire [3:0]  rb_idx_i,
	input  wire [1:0]  rb_size_i,
	output wire [31:0] rb_data_o,
	// Long read ports (base register, stack register)
	input  wire [2:0]  rl_idx_i,
	output wire [31:0] rl_data_o,
	output wire [31:0] sp_data_o,
	// Sized write port
	input  wire        we_i,
	input  wire [3:0]  w_idx_i,
	input  wire [1:0]  w_size_i,
	input  wire [31:0] w_data_i
);

	// No reset: contents, stack register included, are undefined at start
	reg [31:0] regs [0:7];

	// Byte index bit 3 picks low byte, half index bit 3 picks upper half
	function [31:0] sized_read;
		input [31:0] word;
		input [3:0]  idx;
		input [1:0]  size;
		begin
			case (size)
			`DTOD_SZ_BYTE: sized_read = idx[3] ? {24'h00_0000, word[7:0]}
				: {24'h00_0000, word[15:8]};
			`DTOD_SZ_WORD: sized_read = idx[3] ? {16'h0000, word[31:16]}
				: {16'h0000, word[15:0]};
			default:       sized_read = word;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Read views over shared storage
	assign ra_data_o = sized_read(regs[ra_idx_i[2:0]], ra_idx_i, ra_size_i); // RULE_05
	assign rb_data_o = sized_read(regs[rb_idx_i[2:0]], rb_idx_i, rb_size_i); // RULE_05
	assign rl_data_o = regs[rl_idx_i];
	assign sp_data_o = regs[`DTOD_STACK_IDX]; // RULE_07

	////////////////////////////////////////////////////////////////////////
	// Sized write merges into the addressed long register
	always @(posedge sys_clk_i) begin
		if (we_i) begin
			case (w_size_i)
			`DTOD_SZ_BYTE: begin
				if (w_idx_i[3])
					regs[w_idx_i[2:0]][7:0] <= w_data_i[7:0]; // RULE_05
				else
					regs[w_idx_i[2:0]][15:8] <= w_data_i[7:0]; // RULE_05
			end
			`DTOD_SZ_WORD: begin
				if (w_idx_i[3])
					regs[w_idx_i[2:0]][31:16] <= w_data_i[15:0]; // RULE_05
				else
					regs[w_idx_i[2:0]][15:0] <= w_data_i[15:0]; // RULE_05
			end
			default: regs[w_idx_i[2:0]] <= w_data_i; // RULE_05
			endcase
		end
	end

endmodule // dtod_regfile

`default_nettype wire

// >>> hdl/dtod_core.v
/*
 * Decode and execute for the data-transfer group: general transfers,
 * stack pull and place through the stack register, peripheral transfers
 * refused. Holds the register file and a single-access memory port.
 * Assumes a pre-decoded operation at its input and a memory that answers
 * each request with mem_ack_i, presenting sized data in the low bits.
 */
// Summary of operation
// [RULE_01] Transfer reg, memory or immediate, B/W/L
// [RULE_02] Peripheral read/write opcodes unsupported
// [RULE_03] Pull reads at stack, then post-increments
// [RULE_04] Place pre-decrements stack, then writes there
// [RULE_05] Registers viewed as bytes, halves, longs
// [RULE_06] Operand fields decoded as 3/8/16/24 bits
// [RULE_07] Stack is long register seven, not reset
// [RULE_08] Odd word/long address forced even, no error
// [RULE_09] Stack adjusts by two or four bytes
`timescale 1ns/10ps
`default_nettype none

`include "dtod_map.vh"

module dtod_core (
	// Clock and reset
	input  wire        sys_clk_i,
	input  wire        rstn_i,
	// Decoded operation
	input  wire        op_valid_i,
	input  wire [2:0]  op_kind_i,
	input  wire [1:0]  op_size_i,
	input  wire [1:0]  src_sel_i,
	input  wire        dst_mem_i,
	input  wire [3:0]  rs_i,
	input  wire [3:0]  rd_i,
	input  wire [2:0]  base_i,
	input  wire [1:0]  ea_mode_i,
	input  wire [23:0] field_i,
	input  wire [1:0]  field_len_i,
	input  wire        field_sext_i,
	output reg         op_ready_o,
	output reg         done_o,
	output reg         unsupported_o,
	// Memory port
	output reg         mem_req_o,
	output reg         mem_we_o,
	output reg  [23:0] mem_addr_o,
	output reg  [1:0]  mem_size_o,
	output reg  [31:0] mem_wdata_o,
	input  wire        mem_ack_i,
	input  wire [31:0] mem_rdata_i,
	// Register observation
	input  wire [3:0]  obs_idx_i,
	input  wire [1:0]  obs_size_i,
	output reg  [31:0] obs_data_o
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_EXEC = 3'h1;
	localparam [2:0] ST_MEM  = 3'h2;
	localparam [2:0] ST_SPUP = 3'h3;

	reg [2:0]  state;
	reg [2:0]  kind;
	reg [1:0]  size;
	reg [1:0]  src_sel;
	reg        dst_mem;
	reg [3:0]  rs;
	reg [3:0]  rd;
	reg [2:0]  base;
	reg [1:0]  ea_mode;
	reg [31:0] field_val;

	wire [31:0] rs_data;
	wire [31:0] base_data;
	wire [31:0] sp_data;
	wire [31:0] obs_data;

	reg         rf_we;
	reg  [3:0]  rf_idx;
	reg  [1:0]  rf_size;
	reg  [31:0] rf_data;

	////////////////////////////////////////////////////////////////////////
	// Register file
	dtod_regfile u_regs (
		.sys_clk_i (sys_clk_i),
		.ra_idx_i  (rs),
		.ra_size_i (size),
		.ra_data_o (rs_data),
		.rb_idx_i  (obs_idx_i),
		.rb_size_i (obs_size_i),
		.rb_data_o (obs_data),
		.rl_idx_i  (base),
		.rl_data_o (base_data),
		.sp_data_o (sp_data),
		.we_i      (rf_we),
		.w_idx_i   (rf_idx),
		.w_size_i  (rf_size),
		.w_data_i  (rf_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Operand field decode by length, optional sign extension
	function [31:0] decode_field;
		input [23:0] f;
		input [1:0]  len;
		input        sext;
		begin
			case (len)
			`DTOD_LEN_3:  decode_field = {29'h0000_0000, f[2:0]}; // RULE_06
			`DTOD_LEN_8:  decode_field = {{24{sext & f[7]}}, f[7:0]}; // RULE_06
			`DTOD_LEN_16: decode_field = {{16{sext & f[15]}}, f[15:0]}; // RULE_06
			default:      decode_field = {{8{sext & f[23]}}, f}; // RULE_06
			endcase
		end
	endfunction

	// Stack step for the latched size; only word and long are legal here
	wire [31:0] step = (size == `DTOD_SZ_LONG) ? `DTOD_BYTES_LONG
		: `DTOD_BYTES_WORD; // RULE_09

	// Effective address of a general transfer
	reg [31:0] ea;
	always @* begin
		case (ea_mode)
		`DTOD_EA_ABS: ea = field_val;
		`DTOD_EA_IND: ea = base_data;
		default:      ea = base_data + field_val;
		endcase
	end

	// Word and long addresses drop bit zero rather than fault
	function [23:0] align;
		input [31:0] a;
		input [1:0]  sz;
		begin
			if (sz == `DTOD_SZ_BYTE)
				align = a[23:0];
			else
				align = {a[23:1], 1'b0}; // RULE_08
		end
	endfunction

	// Sized read data cut from the memory answer
	reg [31:0] rdata_sized;
	always @* begin
		case (size)
		`DTOD_SZ_BYTE: rdata_sized = {24'h00_0000, mem_rdata_i[7:0]};
		`DTOD_SZ_WORD: rdata_sized = {16'h0000, mem_rdata_i[15:0]};
		default:       rdata_sized = mem_rdata_i;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register write steering
	always @* begin
		rf_we   = 1'b0;
		rf_idx  = rd;
		rf_size = size;
		rf_data = rs_data;
		case (state)
		ST_EXEC: begin
			if (kind == `DTOD_OP_PLACE) begin
				// Stack drops before the write goes out
				rf_we   = 1'b1;
				rf_idx  = {1'b0, `DTOD_STACK_IDX};
				rf_size = `DTOD_SZ_LONG;
				rf_data = sp_data - step; // RULE_04
			end else if (kind == `DTOD_OP_XFER && !dst_mem
				&& src_sel != `DTOD_SRC_MEM) begin
				rf_we   = 1'b1;
				rf_data = (src_sel == `DTOD_SRC_IMM) ? field_val
					: rs_data; // RULE_01
			end
		end
		ST_MEM: begin
			// Read answer lands in the destination register
			rf_we   = mem_ack_i && !mem_we_o;
			rf_data = rdata_sized; // RULE_01
		end
		ST_SPUP: begin
			rf_we   = 1'b1;
			rf_idx  = {1'b0, `DTOD_STACK_IDX};
			rf_size = `DTOD_SZ_LONG;
			rf_data = sp_data + step; // RULE_03
		end
		default: rf_we = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: one operation at a time, at most one memory access each
	always @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			state         <= ST_IDLE;
			kind          <= `DTOD_OP_XFER;
			size          <= `DTOD_SZ_BYTE;
			src_sel       <= `DTOD_SRC_REG;
			dst_mem       <= 1'b0;
			rs            <= 4'h0;
			rd            <= 4'h0;
			base          <= 3'h0;
			ea_mode       <= `DTOD_EA_ABS;
			field_val     <= 32'h0000_0000;
			op_ready_o    <= 1'b0;
			done_o        <= 1'b0;
			unsupported_o <= 1'b0;
			mem_req_o     <= 1'b0;
			mem_we_o      <= 1'b0;
			mem_addr_o    <= 24'h00_0000;
			mem_size_o    <= `DTOD_SZ_BYTE;
			mem_wdata_o   <= 32'h0000_0000;
		end else begin
			done_o        <= 1'b0;
			unsupported_o <= 1'b0;
			case (state)
			ST_IDLE: begin
				op_ready_o <= 1'b1;
				if (op_valid_i && op_ready_o) begin
					op_ready_o <= 1'b0;
					kind       <= op_kind_i;
					size       <= op_size_i;
					src_sel    <= src_sel_i;
					dst_mem    <= dst_mem_i;
					rs         <= rs_i;
					rd         <= rd_i;
					base       <= base_i;
					ea_mode    <= ea_mode_i;
					field_val  <= decode_field(field_i, field_len_i,
						field_sext_i); // RULE_06
					if (op_kind_i == `DTOD_OP_PERIPH_RD
						|| op_kind_i == `DTOD_OP_PERIPH_WR) begin
						// Flagged and retired with no transfer
						unsupported_o <= 1'b1; // RULE_02
						done_o        <= 1'b1;
						op_ready_o    <= 1'b1;
					end else begin
						state <= ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				mem_size_o  <= size;
				mem_wdata_o <= rs_data; // Caught before stack moves
				case (kind)
				`DTOD_OP_PULL: begin
					mem_req_o  <= 1'b1;
					mem_we_o   <= 1'b0;
					mem_addr_o <= align(sp_data, size); // RULE_03
					state      <= ST_MEM;
				end
				`DTOD_OP_PLACE: begin
					mem_req_o  <= 1'b1;
					mem_we_o   <= 1'b1;
					mem_addr_o <= align(sp_data - step, size); // RULE_04
					state      <= ST_MEM;
				end
				default: begin
					if (dst_mem || src_sel == `DTOD_SRC_MEM) begin
						mem_req_o  <= 1'b1;
						mem_we_o   <= dst_mem; // RULE_01
						mem_addr_o <= align(ea, size); // RULE_08
						state      <= ST_MEM;
					end else begin
						done_o     <= 1'b1;
						op_ready_o <= 1'b1;
						state      <= ST_IDLE;
					end
				end
				endcase
			end
			ST_MEM: begin
				if (mem_ack_i) begin
					mem_req_o <= 1'b0;
					mem_we_o  <= 1'b0;
					if (kind == `DTOD_OP_PULL) begin
						state <= ST_SPUP; // RULE_03
					end else begin
						done_o     <= 1'b1;
						op_ready_o <= 1'b1;
						state      <= ST_IDLE;
					end
				end
			end
			ST_SPUP: begin
				done_o     <= 1'b1;
				op_ready_o <= 1'b1;
				state      <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Observation port, registered so the output is a flop
	always @(posedge sys_clk_i) begin
		if (!rstn_i)
			obs_data_o <= 32'h0000_0000;
		else
			obs_data_o <= obs_data; // Follows undefined regs until written
	end

endmodule // dtod_core

`default_nettype wire

// >>> test/dtod_core_sva.sv
/* Checker for the dtod_core port timing and memory relations.
   Assumes it is bound to dtod_core and sees only the core's ports. */
`timescale 1ns/10ps
`default_nettype none
`include "dtod_map.vh"
module dtod_core_chk (
	// Clock, reset and operation port
	input wire logic        sys_clk_i,
	input wire logic        rstn_i,
	input wire logic        op_valid_i,
	input wire logic [2:0]  op_kind_i,
	input wire logic [1:0]  src_sel_i,
	input wire logic        dst_mem_i,
	input wire logic        op_ready_o,
	input wire logic        done_o,
	input wire logic        unsupported_o,
	// Memory port
	input wire logic        mem_req_o,
	input wire logic        mem_we_o,
	input wire logic [23:0] mem_addr_o,
	input wire logic [1:0]  mem_size_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic        mem_ack_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// Operation taken, and the kinds that matter here
	wire tk = op_valid_i && op_ready_o;
	wire per = op_kind_i == `DTOD_OP_PERIPH_RD
		|| op_kind_i == `DTOD_OP_PERIPH_WR;
	wire rx = op_kind_i == `DTOD_OP_XFER && src_sel_i != `DTOD_SRC_MEM
		&& !dst_mem_i;
	property p_even; mem_req_o && mem_size_o != `DTOD_SZ_BYTE
		|-> !mem_addr_o[0]; endproperty
	a_even: assert property (p_even) else $error("odd wide address");
	property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable({mem_we_o,
		mem_addr_o, mem_size_o, mem_wdata_o}); endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_regx; tk && rx |=> (!mem_req_o && !done_o && !op_ready_o)
		##1 (done_o && op_ready_o && !mem_req_o); endproperty
	a_regx: assert property (p_regx) else $error("reg move timing");
	property p_unsup; tk && per |=> done_o && unsupported_o && !mem_req_o;
	endproperty
	a_unsup: assert property (p_unsup) else $error("periph op run");
	property p_pull; tk && op_kind_i == `DTOD_OP_PULL
		|-> ##[1:2] (mem_req_o && !mem_we_o); endproperty
	a_pull: assert property (p_pull) else $error("pull not a read");
	property p_place; tk && op_kind_i == `DTOD_OP_PLACE
		|-> ##[1:2] (mem_req_o && mem_we_o); endproperty
	a_place: assert property (p_place) else $error("place not a write");
	property p_wdone; mem_req_o && mem_ack_i && mem_we_o
		|=> done_o && !mem_req_o; endproperty
	a_wdone: assert property (p_wdone) else $error("write end");
	property p_rdone; mem_req_o && mem_ack_i && !mem_we_o
		|=> !mem_req_o ##[0:2] done_o; endproperty
	a_rdone: assert property (p_rdone) else $error("read end");
	c_pull: cover property (tk && op_kind_i == `DTOD_OP_PULL);
	c_place: cover property (tk && op_kind_i == `DTOD_OP_PLACE);
	c_per: cover property (unsupported_o);
endmodule // dtod_core_chk
bind dtod_core dtod_core_chk i_chk (.*);
`default_nettype wire

// >>> test/dtod_mem_model.sv
/* Byte memory answering the core's single-access port, big-endian lanes.
   Assumes one request at a time; wait_i sets the answer delay. */
`timescale 1ns/10ps
`default_nettype none
`include "dtod_map.vh"
module dtod_mem_model (
	// Request side
	input wire logic        sys_clk_i,
	input wire logic        mem_req_i,
	input wire logic        mem_we_i,
	input wire logic [23:0] mem_addr_i,
	input wire logic [1:0]  mem_size_i,
	input wire logic [31:0] mem_wdata_i,
	input wire logic [3:0]  wait_i,
	// Answer side
	output logic            mem_ack_o,
	output logic [31:0]     mem_rdata_o
);
	logic [7:0]  mem [0:255];
	logic [3:0]  cnt = 4'h0;
	logic [31:0] junk = 32'h5a5a_a5a5;
	logic [7:0]  a;
	int          nb;
	// Ack after wait_i held cycles; zero means same cycle
	assign mem_ack_o = mem_req_i && cnt == wait_i;
	assign a = mem_addr_i[7:0];
	// Odd addresses are not corrected here, so the core must do it
	always_comb begin
		case (mem_size_i)
		`DTOD_SZ_BYTE: mem_rdata_o = {24'h00_0000, mem[a]};
		`DTOD_SZ_WORD: mem_rdata_o = {16'h0000, mem[a], mem[a + 8'h01]};
		default: mem_rdata_o = {mem[a], mem[a + 8'h01], mem[a + 8'h02],
			mem[a + 8'h03]};
		endcase
		if (!mem_ack_o || mem_we_i)
			mem_rdata_o = junk;
		nb = mem_size_i == `DTOD_SZ_BYTE ? 1 : mem_size_i == `DTOD_SZ_WORD ? 2 : 4;
	end
	// Wait count, write lanes, and a junk word that toggles every cycle
	always @(posedge sys_clk_i) begin
		junk <= ~junk;
		cnt <= (mem_req_i && !mem_ack_o) ? cnt + 4'h1 : 4'h0;
		if (mem_ack_o && mem_we_i)
			for (int i = 0; i < nb; i++)
				mem[a + 8'(i)] <= mem_wdata_i[8 * (nb - 1 - i) +: 8];
	end
endmodule // dtod_mem_model
`default_nettype wire

// >>> test/dtod_core_tb_top.sv
/* Bench for dtod_core with the memory model; one task per scenario.
   Assumes the checker is bound and dtod_map.vh is on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "dtod_map.vh"
module dtod_core_tb_top;
	// Driven inputs, all given values at time zero
	logic        sys_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        op_valid_i = 1'b0;
	logic [2:0]  op_kind_i = 3'h0;
	logic [1:0]  op_size_i = 2'h0;
	logic [1:0]  src_sel_i = 2'h0;
	logic        dst_mem_i = 1'b0;
	logic [3:0]  rs_i = 4'h0;
	logic [3:0]  rd_i = 4'h0;
	logic [2:0]  base_i = 3'h0;
	logic [1:0]  ea_mode_i = 2'h0;
	logic [23:0] field_i = 24'h00_0000;
	logic [1:0]  field_len_i = 2'h0;
	logic        field_sext_i = 1'b0;
	logic [3:0]  obs_idx_i = 4'h0;
	logic [1:0]  obs_size_i = 2'h0;
	logic [3:0]  mem_wait = 4'h0;
	// Observed outputs
	logic        op_ready_o, done_o, unsupported_o, uns;
	logic        mem_req_o, mem_we_o, mem_ack_i;
	logic [23:0] mem_addr_o;
	logic [1:0]  mem_size_o;
	logic [31:0] mem_wdata_o, mem_rdata_i, obs_data_o;
	int          errors = 0;
	int          checks = 0;
	always #2 sys_clk_i = ~sys_clk_i;
	dtod_core i_dut (.*);
	dtod_mem_model i_mem (.sys_clk_i(sys_clk_i), .mem_req_i(mem_req_o),
		.mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_size_i(mem_size_o),
		.mem_wdata_i(mem_wdata_o), .wait_i(mem_wait), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i));
	////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Offer one op when ready, wait bounded for its done pulse
	task automatic issue(input logic [2:0] k, input logic [1:0] sz, sr,
		input logic [3:0] rs, rd, input logic [23:0] f, input logic [1:0] fl);
		int n;
		n = 0;
		while (op_ready_o !== 1'b1 && n < 50) begin
			@(negedge sys_clk_i);
			n++;
		end
		{op_kind_i, op_size_i, src_sel_i} = {k, sz, sr};
		{rs_i, rd_i, field_i, field_len_i} = {rs, rd, f, fl};
		op_valid_i = 1'b1;
		@(negedge sys_clk_i);
		op_valid_i = 1'b0;
		while (done_o !== 1'b1 && n < 100) begin
			@(negedge sys_clk_i);
			n++;
		end
		uns = unsupported_o;
		if (n >= 100) begin
			errors++;
			complete_run;
		end
	endtask
	task automatic imm(input logic [1:0] sz, input logic [3:0] rd,
		input logic [23:0] f, input logic [1:0] fl, input logic s);
		field_sext_i = s;
		issue(`DTOD_OP_XFER, sz, `DTOD_SRC_IMM, 4'h0, rd, f, fl);
	endtask
	task automatic stk(input logic [2:0] k, input logic [1:0] sz,
		input logic [3:0] r);
		issue(k, sz, `DTOD_SRC_REG, r, r, 24'h00_0000, `DTOD_LEN_8);
	endtask
	// Registered view, one edge after index and size
	task automatic obs(input logic [3:0] i, input logic [1:0] sz,
		input logic [31:0] exp);
		{obs_idx_i, obs_size_i} = {i, sz};
		@(negedge sys_clk_i);
		check("obs", obs_data_o, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Immediates of each field length, read through each view
	task automatic s_imm;
		imm(`DTOD_SZ_LONG, 4'h1, 24'h12_3456, `DTOD_LEN_24, 1'b0);
		imm(`DTOD_SZ_BYTE, 4'h9, 24'h00_00ab, `DTOD_LEN_8, 1'b1);
		obs(4'h1, `DTOD_SZ_LONG, 32'h0012_34ab);
		obs(4'h9, `DTOD_SZ_WORD, 32'h0000_0012);
		obs(4'h1, `DTOD_SZ_BYTE, 32'h0000_0034);
		imm(`DTOD_SZ_LONG, 4'h3, 24'h00_8000, `DTOD_LEN_16, 1'b1);
		obs(4'h3, `DTOD_SZ_LONG, 32'hffff_8000);
		imm(`DTOD_SZ_WORD, 4'hb, 24'hff_ffff, `DTOD_LEN_3, 1'b1);
		obs(4'h3, `DTOD_SZ_LONG, 32'h0007_8000);
	endtask
	// Back-to-back register moves, long then word into an upper half
	task automatic s_move;
		issue(`DTOD_OP_XFER, `DTOD_SZ_LONG, `DTOD_SRC_REG, 4'h1, 4'h2,
			24'h00_0000, `DTOD_LEN_8);
		issue(`DTOD_OP_XFER, `DTOD_SZ_WORD, `DTOD_SRC_REG, 4'h1, 4'ha,
			24'h00_0000, `DTOD_LEN_8);
		check("unsup", {31'h0, uns}, 32'h0000_0000);
		obs(4'h2, `DTOD_SZ_LONG, 32'h34ab_34ab);
	endtask
	// Slow memory, word write and read at an odd address
	task automatic s_mem;
		mem_wait = 4'h2;
		dst_mem_i = 1'b1;
		issue(`DTOD_OP_XFER, `DTOD_SZ_WORD, `DTOD_SRC_REG, 4'h1, 4'h0,
			24'h00_0041, `DTOD_LEN_8);
		dst_mem_i = 1'b0;
		check("mem", {i_mem.mem[8'h40], i_mem.mem[8'h41]}, 32'h34ab);
		issue(`DTOD_OP_XFER, `DTOD_SZ_WORD, `DTOD_SRC_MEM, 4'h0, 4'h4,
			24'h00_0041, `DTOD_LEN_8);
		obs(4'h4, `DTOD_SZ_WORD, 32'h0000_34ab);
	endtask
	// Prompt memory, places then pulls of both sizes
	task automatic s_stack;
		mem_wait = 4'h0;
		imm(`DTOD_SZ_LONG, 4'h7, 24'h00_0080, `DTOD_LEN_24, 1'b0);
		stk(`DTOD_OP_PLACE, `DTOD_SZ_LONG, 4'h1);
		obs(4'h7, `DTOD_SZ_LONG, 32'h0000_007c);
		check("mem", {i_mem.mem[8'h7c], i_mem.mem[8'h7d], i_mem.mem[8'h7e],
			i_mem.mem[8'h7f]}, 32'h0012_34ab);
		stk(`DTOD_OP_PLACE, `DTOD_SZ_WORD, 4'h2);
		obs(4'h7, `DTOD_SZ_LONG, 32'h0000_007a);
		stk(`DTOD_OP_PULL, `DTOD_SZ_WORD, 4'h6);
		obs(4'h6, `DTOD_SZ_WORD, 32'h0000_34ab);
		stk(`DTOD_OP_PULL, `DTOD_SZ_LONG, 4'h0);
		obs(4'h0, `DTOD_SZ_LONG, 32'h0012_34ab);
		obs(4'h7, `DTOD_SZ_LONG, 32'h0000_0080);
	endtask
	// Stack base plus negative 24-bit offset, odd sum; then plain @base
	task automatic s_ea;
		{ea_mode_i, base_i, field_sext_i} = {`DTOD_EA_DISP, 3'h7, 1'b1};
		issue(`DTOD_OP_XFER, `DTOD_SZ_LONG, `DTOD_SRC_MEM, 4'h0, 4'h5,
			24'hff_fffd, `DTOD_LEN_24);
		obs(4'h5, `DTOD_SZ_LONG, 32'h0012_34ab);
		ea_mode_i = `DTOD_EA_IND;
		dst_mem_i = 1'b1;
		issue(`DTOD_OP_XFER, `DTOD_SZ_WORD, `DTOD_SRC_REG, 4'h5, 4'h0,
			24'h00_0000, `DTOD_LEN_8);
		{dst_mem_i, ea_mode_i, base_i} = {1'b0, `DTOD_EA_ABS, 3'h0};
		check("mem", {i_mem.mem[8'h80], i_mem.mem[8'h81]}, 32'h34ab);
	endtask
	// Peripheral kinds refused, memory left alone
	task automatic s_periph;
		i_mem.mem[8'h10] = 8'h5a;
		for (int k = `DTOD_OP_PERIPH_RD; k <= `DTOD_OP_PERIPH_WR; k++) begin
			issue(3'(k), `DTOD_SZ_BYTE, `DTOD_SRC_MEM, 4'h5, 4'h5,
				24'h00_0010, `DTOD_LEN_8);
			check("unsup", {31'h0, uns}, 32'h0000_0001);
		end
		check("mem", {24'h00_0000, i_mem.mem[8'h10]}, 32'h0000_005a);
	endtask
	initial begin
		repeat (3) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		s_imm;
		s_move;
		s_mem;
		s_stack;
		s_ea;
		s_periph;
		complete_run;
	end
endmodule // dtod_core_tb_top
`default_nettype wire
